//--- bench/testbench.sv
// self-checking bench for the cpu status and mode state block
`default_nettype none
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
    $display("MISMATCH t=%0t %s", $time, msg); end end
module testbench import csm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [15:0] sw;
        logic [7:0]  alt;
        logic [31:0] pcv;
        logic [31:0] sp;
        logic        fault;
        logic        admit;
    } csm_note_t;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        opValid = 1'b0, irqTake = 1'b0, aluValid = 1'b0, aluKindOvf = 1'b0;
    logic        aluCarry = 1'b0, aluOverflow = 1'b0, aluSub = 1'b0;
    logic        pcWrite = 1'b0, spWrite = 1'b0;
    csm_op_t     opCode = CSM_OP_NOP;
    csm_width_t  aluWidth = CSM_W8;
    logic [31:0] opData = 32'h0, aluA = 32'h0, aluB = 32'h0, aluResult = 32'h0;
    logic [31:0] pcIn = 32'h0, spIn = 32'h0;
    logic [3:0]  crAddr = 4'h0;
    logic [2:0]  irqLevel = 3'h0, irqReqLevel = 3'h0;
    logic [15:0] statusWord;
    logic [7:0]  altFlags;
    logic [31:0] pc, activeSp, crRdData;
    logic        privFault, irqAdmit, crRdValid;
    int          num_errors = 0;
    int          check_count = 0;
    logic [31:0] seed = 32'd89982;
    csm_note_t   q [$];
    logic [31:0] crQ [$];
    logic [15:0] mSw;
    logic [7:0]  mAlt;
    logic [31:0] mPc, mSys, mUsr;
    logic [31:0] crMem [16];
    logic        sTake = 1'b0, sAlu = 1'b0, sPcw = 1'b0, sSpw = 1'b0;
    logic        sKind = 1'b0, sCy = 1'b0, sOv = 1'b0, sSub = 1'b0;
    logic [2:0]  sLvl = 3'h0, sReq = 3'h0;
    csm_width_t  sW = CSM_W8;
    logic [31:0] sA = 32'h0, sB = 32'h0, sR = 32'h0, sVal = 32'h0;
    csm_op_t     privOps [6] = '{CSM_OP_TO_USER, CSM_OP_MASK_LOAD, CSM_OP_WIDEN,
                                 CSM_OP_SR_RESTORE, CSM_OP_CR_READ, CSM_OP_CR_WRITE};

    csm_state_core #(.CR_AW(4)) csm_state_core_i (
        .clk_sys(clk_sys), .rst(rst), .opValid(opValid), .opCode(opCode), .opData(opData),
        .crAddr(crAddr), .irqTake(irqTake), .irqLevel(irqLevel), .irqReqLevel(irqReqLevel),
        .aluValid(aluValid), .aluWidth(aluWidth), .aluKindOvf(aluKindOvf), .aluA(aluA),
        .aluB(aluB), .aluResult(aluResult), .aluCarry(aluCarry), .aluOverflow(aluOverflow),
        .aluSub(aluSub), .pcWrite(pcWrite), .pcIn(pcIn), .spWrite(spWrite), .spIn(spIn),
        .statusWord(statusWord), .altFlags(altFlags), .pc(pc), .activeSp(activeSp),
        .privFault(privFault), .irqAdmit(irqAdmit), .crRdData(crRdData),
        .crRdValid(crRdValid)
    );

    always #50 clk_sys = ~clk_sys;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] aluf(input logic [7:0] old);
        logic [31:0] m;
        logic        s;
        m = (sW == CSM_W8) ? 32'h0000_00ff : (sW == CSM_W16) ? 32'h0000_ffff : 32'hffff_ffff;
        s = (sW == CSM_W8) ? sR[7] : (sW == CSM_W16) ? sR[15] : sR[31];
        return {s, (sR & m) == 32'h0, 1'b0, (sW == CSM_W32) ? old[4] : sA[4] ^ sB[4] ^ sR[4],
                1'b0, sKind ? sOv : (sW == CSM_W32) ? old[2] : ~^sR[7:0], sSub, sCy};
    endfunction

    // one clock of stimulus, with the model stepped alongside
    task automatic cyc(input csm_op_t op = CSM_OP_NOP, input logic [31:0] d = 32'h0,
                       input logic [3:0] a = 4'h0);
        logic flt;
        logic lvl;
        logic act;
        @(posedge clk_sys);
        opValid <= (op != CSM_OP_NOP);
        opCode <= op;
        opData <= d;
        crAddr <= a;
        irqTake <= sTake;
        irqLevel <= sLvl;
        irqReqLevel <= sReq;
        aluValid <= sAlu;
        aluWidth <= sW;
        aluKindOvf <= sKind;
        aluA <= sA;
        aluB <= sB;
        aluResult <= sR;
        aluCarry <= sCy;
        aluOverflow <= sOv;
        aluSub <= sSub;
        pcWrite <= sPcw;
        pcIn <= sVal;
        spWrite <= sSpw;
        spIn <= sVal;
        flt = 1'b0;
        act = sTake || sAlu || sPcw || sSpw || op != CSM_OP_NOP;
        lvl = mSw[15];
        if (sAlu) mSw[7:0] = aluf(mSw[7:0]);
        if (sSpw && lvl) mSys = sVal;
        if (sSpw && !lvl) mUsr = sVal;
        if (sPcw) mPc = sVal;
        if (sTake) begin
            mSw[15] = 1'b1;
            mSw[14:12] = (sLvl == 3'h7) ? 3'h7 : sLvl + 3'h1;
        end else if (!lvl && op inside {privOps}) begin
            flt = 1'b1;
        end else begin
            case (op)
                CSM_OP_TO_USER: mSw[15] = 1'b0;
                CSM_OP_MASK_LOAD: mSw[14:12] = d[2:0];
                CSM_OP_WIDEN: mSw[11] = 1'b1;
                CSM_OP_BANK_LOAD: mSw[10:8] = d[2:0];
                CSM_OP_BANK_INC: mSw[10:8] = mSw[10:8] + 3'h1;
                CSM_OP_BANK_DEC: mSw[10:8] = mSw[10:8] - 3'h1;
                CSM_OP_FLAG_SWAP: {mSw[7:0], mAlt} = {mAlt, mSw[7:0]};
                CSM_OP_FLAG_WRITE: mSw[7:0] = d[7:0] & 8'hd7;
                CSM_OP_SR_RESTORE: mSw = d[15:0] & 16'hffd7;
                CSM_OP_CR_WRITE: begin
                    crMem[a] = d;
                    if (a == 4'h0) mUsr = d;
                end
                CSM_OP_CR_READ: crQ.push_back((a == 4'h0) ? mUsr : crMem[a]);
                default: ;
            endcase
        end
        if (mSw[11]) mSw[10] = 1'b0;
        if (!mSw[11]) mPc = mPc & 32'h0000_ffff;
        if (act) q.push_back(csm_note_t'{mSw, mAlt, mPc, mSw[15] ? mSys : mUsr, flt,
                                         sReq != 3'h0 && sReq >= mSw[14:12]});
        sTake = 1'b0;
        sAlu = 1'b0;
        sPcw = 1'b0;
        sSpw = 1'b0;
    endtask

    always @(posedge clk_sys) begin : mon
        csm_note_t n;
        if (!rst && (opValid || irqTake || aluValid || pcWrite || spWrite)) begin
            #1;
            if (q.size() == 0) begin
                `CHK(1'b0, 1'b1, "result without note")
            end else begin
                n = q.pop_front();
                `CHK(statusWord[15:8], n.sw[15:8], "status upper")
                `CHK(statusWord[7:0], n.sw[7:0], "flag byte")
                `CHK(altFlags, n.alt, "alternate flags")
                `CHK(pc, n.pcv, "program counter")
                `CHK(activeSp, n.sp, "active stack pointer")
                `CHK(privFault, n.fault, "privilege fault")
                `CHK(irqAdmit, n.admit, "irq admit")
            end
        end
    end

    always @(posedge clk_sys) begin : crmon
        #1;
        if (crRdValid === 1'b1) begin
            if (crQ.size() == 0) begin
                `CHK(1'b0, 1'b1, "unexpected control read")
            end else begin
                `CHK(crRdData, crQ.pop_front(), "control read data")
            end
        end
    end

    task automatic drain();
        int k;
        cyc();
        for (k = 0; k < 20 && (q.size() != 0 || crQ.size() != 0); k++) @(posedge clk_sys);
        if (q.size() != 0 || crQ.size() != 0) `CHK(1'b0, 1'b1, "results missing")
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        mSw = 16'hf000;
        mAlt = 8'h00;
        mPc = 32'h0000_8000;
        mSys = 32'h0000_0100;
        `CHK(statusWord[15:8], 8'hf0, "reset status")
        `CHK(pc, 32'h0000_8000, "reset pc")
        `CHK(activeSp, 32'h0000_0100, "reset stack")
    endtask

    task automatic test_done(input string s);
        $display("test %s done, mismatches so far %0d", s, num_errors);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin : watchdog
        #3_000_000;
        `CHK(1'b0, 1'b1, "run did not finish")
        tally_and_finish();
    end

    initial begin : main
        logic [31:0] r;
        int          i;
        do_reset();
        repeat (16) begin
            r = rnd();
            sAlu = 1'b1;
            sW = csm_width_t'(r[1:0] % 2'd3);
            sKind = (sW == CSM_W16) | r[2];
            sA = rnd();
            sB = rnd();
            sR = r[3] ? 32'h0 : rnd();
            sCy = r[4];
            sOv = r[5];
            sSub = r[6];
            cyc();
        end
        test_done("alu flags");
        cyc(CSM_OP_FLAG_WRITE, 32'h0000_00ff);
        cyc(CSM_OP_FLAG_SWAP);
        cyc(CSM_OP_FLAG_WRITE, 32'h0000_0041);
        cyc(CSM_OP_FLAG_SWAP);
        test_done("flag swap");
        cyc(CSM_OP_BANK_LOAD, 32'h7);
        cyc(CSM_OP_BANK_INC);
        cyc(CSM_OP_BANK_DEC);
        cyc(CSM_OP_BANK_DEC);
        cyc(CSM_OP_BANK_LOAD, 32'h0);
        cyc(CSM_OP_BANK_DEC);
        test_done("bank pointer");
        for (i = 0; i < 8; i++) begin
            sReq = 3'(7 - i);
            cyc(CSM_OP_MASK_LOAD, 32'(i));
        end
        sReq = 3'h1;
        cyc(CSM_OP_MASK_LOAD, 32'h0);
        cyc(CSM_OP_MASK_LOAD, 32'h1);
        test_done("mask load");
        cyc(CSM_OP_CR_WRITE, 32'h0000_2468, 4'h0);
        cyc(CSM_OP_CR_WRITE, 32'h1357_9bdf, 4'h5);
        cyc(CSM_OP_CR_READ, 32'h0, 4'h0);
        cyc(CSM_OP_CR_READ, 32'h0, 4'h5);
        sSpw = 1'b1;
        sVal = 32'h0000_0200;
        cyc();
        sPcw = 1'b1;
        sVal = 32'h0001_2345;
        cyc();
        drain();
        test_done("control space");
        cyc(CSM_OP_TO_USER);
        foreach (privOps[j]) cyc(privOps[j], 32'h0000_ffff, 4'h0);
        sSpw = 1'b1;
        sVal = 32'h0000_3000;
        cyc();
        cyc(CSM_OP_BANK_INC);
        test_done("user level");
        sTake = 1'b1;
        sLvl = 3'h7;
        cyc(CSM_OP_BANK_INC);
        cyc(CSM_OP_TO_USER);
        sTake = 1'b1;
        sLvl = 3'h3;
        cyc();
        test_done("interrupt entry");
        cyc(CSM_OP_WIDEN);
        sPcw = 1'b1;
        sVal = 32'h00ab_cdef;
        cyc();
        cyc(CSM_OP_BANK_LOAD, 32'h7);
        cyc(CSM_OP_BANK_INC);
        cyc(CSM_OP_BANK_DEC);
        cyc(CSM_OP_SR_RESTORE, 32'h0000_7a28);
        drain();
        test_done("wide mode");
        do_reset();
        cyc(CSM_OP_BANK_INC);
        drain();
        test_done("second reset");
        tally_and_finish();
    end
endmodule
`default_nettype wire

//--- verilog/csm_alu_if.sv
// result bundle between the core and its flag calculator
`default_nettype none
interface csm_alu_if;
    import csm_pkg::*;
    logic [31:0] res;
    logic [31:0] a;
    logic [31:0] b;
    csm_width_t  width;
    logic        isOvf;
    logic        carry;
    logic        ovf;
    logic        sub;
    logic [7:0]  oldFlags;
    logic [7:0]  newFlags;
    modport core (output res, a, b, width, isOvf, carry, ovf, sub, oldFlags,
                  input newFlags);
    modport calc (input res, a, b, width, isOvf, carry, ovf, sub, oldFlags,
                  output newFlags);
endinterface
`default_nettype wire

//--- verilog/csm_ctrl_mem.sv
// control register storage with registered read
`default_nettype none
module csm_ctrl_mem #(
    parameter int AW = 4,
    parameter int DW = 32
) (
    input  wire logic          clk_sys,
    input  wire logic          we,
    input  wire logic [AW-1:0] wAddr,
    input  wire logic [DW-1:0] wData,
    input  wire logic          re,
    input  wire logic [AW-1:0] rAddr,
    output logic      [DW-1:0] rdData
);
    logic [DW-1:0] mem [2**AW];
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[wAddr] <= wData;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (re) begin
            rdData <= mem[rAddr];
        end
    end
endmodule
`default_nettype wire

//--- verilog/csm_defs.svh
// constants for the cpu status and mode state block
// Operation
// - 16-bit status word, fields in upper byte
// - level bit: reset 1, user return 0, irq 1
// - privileged op at user level faults instead
// - mask resets 111; admits nonzero level >= mask
// - accepted irq loads mask level+1, 7 stays 111
// - mask load takes effect at once
// - width bit resets 0; widen op sets 1
// - bank resets 000; top bit 0 when wide
// - bank changed only by load, inc, dec, restore, widen
// - bank inc/dec wrap around modulo eight, four when wide
// - sign flag copies result msb
// - zero flag on zero result; bits 5,3 zero
// - half carry from bit 3 to 4
// - parity even gives 1; overflow gives 1
// - subtract flag: add clears, sub sets
// - carry flag on carry or borrow
// - swap exchanges primary and alternate flags
// - stack pointer chosen by operating level
// - reset loads system stack 100h only
// - pc 16 bits narrow, 32 bits wide
// - widening zeroes pc upper half
// - reset loads pc with 8000h
// - control space only via privileged move
`ifndef CSM_DEFS_SVH
`define CSM_DEFS_SVH
`define CSM_SR_LVL     15
`define CSM_SR_MASK    14:12
`define CSM_SR_WIDE    11
`define CSM_SR_BANK    10:8
`define CSM_SR_BANK_TOP 10
`define CSM_SR_FLAGS   7:0
`define CSM_FL_S       7
`define CSM_FL_Z       6
`define CSM_FL_Z5      5
`define CSM_FL_H       4
`define CSM_FL_Z3      3
`define CSM_FL_V       2
`define CSM_FL_N       1
`define CSM_FL_C       0
`define CSM_RST_LVL    1'b1
`define CSM_RST_WIDE   1'b0
`define CSM_RST_MASK   3'h7
`define CSM_MASK_NMI   3'h7
`define CSM_RST_BANK   3'h0
`define CSM_RST_FLAGS  8'h00
`define CSM_RST_SP     32'h0000_0100
`define CSM_RST_PC     32'h0000_8000
`define CSM_PC_NARROW  32'h0000_ffff
`define CSM_CR_USP     4'h0
`endif

//--- verilog/csm_flag_calc.sv
// flag byte computation from an alu result
`include "csm_defs.svh"
`default_nettype none
module csm_flag_calc
    import csm_pkg::*;
(
    csm_alu_if.calc bus
);
    logic [31:0] r;
    logic        sgn;
    logic [7:0]  f;
    always_comb begin
        case (bus.width)
            CSM_W8: begin
                r   = {24'h0, bus.res[7:0]};
                sgn = bus.res[7];
            end
            CSM_W16: begin
                r   = {16'h0, bus.res[15:0]};
                sgn = bus.res[15];
            end
            default: begin
                r   = bus.res;
                sgn = bus.res[31];
            end
        endcase
        f = bus.oldFlags;
        f[`CSM_FL_S] = sgn;
        f[`CSM_FL_Z] = (r == 32'h0);
        f[`CSM_FL_N] = bus.sub;
        f[`CSM_FL_C] = bus.carry;
        // 32-bit ops leave half carry and parity as they were
        if (bus.width != CSM_W32) begin
            f[`CSM_FL_H] = bus.a[4] ^ bus.b[4] ^ bus.res[4];
        end
        if (bus.isOvf) begin
            f[`CSM_FL_V] = bus.ovf;
        end else if (bus.width != CSM_W32) begin
            f[`CSM_FL_V] = ~^r;
        end
        f[`CSM_FL_Z5] = 1'b0;
        f[`CSM_FL_Z3] = 1'b0;
        bus.newFlags = f;
    end
endmodule
`default_nettype wire

//--- verilog/csm_pkg.sv
// types for the cpu status and mode state block
`default_nettype none
package csm_pkg;
    typedef enum logic [3:0] {
        CSM_OP_TO_USER, CSM_OP_MASK_LOAD, CSM_OP_WIDEN, CSM_OP_BANK_LOAD,
        CSM_OP_BANK_INC, CSM_OP_BANK_DEC, CSM_OP_FLAG_SWAP, CSM_OP_FLAG_WRITE,
        CSM_OP_SR_RESTORE, CSM_OP_CR_READ, CSM_OP_CR_WRITE, CSM_OP_NOP
    } csm_op_t;
    typedef enum logic [1:0] {CSM_W8, CSM_W16, CSM_W32} csm_width_t;
endpackage
`default_nettype wire

//--- verilog/csm_state_core.sv
// status word, stack pointers, pc and control space of the cpu core
`include "csm_defs.svh"
`default_nettype none
module csm_state_core
    import csm_pkg::*;
#(
    parameter int CR_AW = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             opValid,
    input  wire csm_op_t          opCode,
    input  wire logic [31:0]      opData,
    input  wire logic [CR_AW-1:0] crAddr,
    input  wire logic             irqTake,
    input  wire logic [2:0]       irqLevel,
    input  wire logic [2:0]       irqReqLevel,
    input  wire logic             aluValid,
    input  wire csm_width_t       aluWidth,
    input  wire logic             aluKindOvf,
    input  wire logic [31:0]      aluA,
    input  wire logic [31:0]      aluB,
    input  wire logic [31:0]      aluResult,
    input  wire logic             aluCarry,
    input  wire logic             aluOverflow,
    input  wire logic             aluSub,
    input  wire logic             pcWrite,
    input  wire logic [31:0]      pcIn,
    input  wire logic             spWrite,
    input  wire logic [31:0]      spIn,
    output logic      [15:0]      statusWord,
    output logic      [7:0]       altFlags,
    output logic      [31:0]      pc,
    output logic      [31:0]      activeSp,
    output logic                  privFault,
    output logic                  irqAdmit,
    output logic      [31:0]      crRdData,
    output logic                  crRdValid
);
    function automatic logic privileged(input csm_op_t op);
        return op inside {CSM_OP_TO_USER, CSM_OP_MASK_LOAD, CSM_OP_WIDEN,
                          CSM_OP_SR_RESTORE, CSM_OP_CR_READ, CSM_OP_CR_WRITE};
    endfunction

    function automatic logic admits(input logic [2:0] mask, input logic [2:0] lvl);
        return (lvl != 3'h0) && (lvl >= mask);
    endfunction

    logic [31:0]      sysSp;
    logic [31:0]      userSp;
    logic             fault;
    logic             doOp;
    logic [15:0]      next_status;
    logic [7:0]       next_alt;
    logic [31:0]      next_pc;
    logic [31:0]      next_sysSp;
    logic [31:0]      next_userSp;
    logic             crWe;
    logic             crRe;
    logic             crRdPend;
    logic [CR_AW-1:0] crRdAddr;
    logic [31:0]      memRdData;

    csm_alu_if aluBus ();
    assign aluBus.res      = aluResult;
    assign aluBus.a        = aluA;
    assign aluBus.b        = aluB;
    assign aluBus.width    = aluWidth;
    assign aluBus.isOvf    = aluKindOvf;
    assign aluBus.carry    = aluCarry;
    assign aluBus.ovf      = aluOverflow;
    assign aluBus.sub      = aluSub;
    assign aluBus.oldFlags = statusWord[`CSM_SR_FLAGS];

    csm_flag_calc u_flags (
        .bus (aluBus.calc)
    );

    // interrupt acceptance outranks any instruction in the same cycle
    always_comb begin
        fault = opValid && privileged(opCode) && !statusWord[`CSM_SR_LVL];
        doOp  = opValid && !fault && !irqTake;
        crWe  = doOp && (opCode == CSM_OP_CR_WRITE);
        crRe  = doOp && (opCode == CSM_OP_CR_READ);
    end

    always_comb begin
        next_status = statusWord;
        next_alt    = altFlags;
        if (aluValid) begin
            next_status[`CSM_SR_FLAGS] = aluBus.newFlags;
        end
        if (irqTake) begin
            next_status[`CSM_SR_LVL] = 1'b1;
            if (irqLevel == `CSM_MASK_NMI) begin
                next_status[`CSM_SR_MASK] = `CSM_MASK_NMI;
            end else begin
                next_status[`CSM_SR_MASK] = irqLevel + 3'h1;
            end
        end else if (doOp) begin
            case (opCode)
                CSM_OP_TO_USER: begin
                    next_status[`CSM_SR_LVL] = 1'b0;
                end
                CSM_OP_MASK_LOAD: begin
                    next_status[`CSM_SR_MASK] = opData[2:0];
                end
                CSM_OP_WIDEN: begin
                    next_status[`CSM_SR_WIDE] = 1'b1;
                end
                CSM_OP_BANK_LOAD: begin
                    next_status[`CSM_SR_BANK] = opData[2:0];
                end
                CSM_OP_BANK_INC: begin
                    next_status[`CSM_SR_BANK] = statusWord[`CSM_SR_BANK] + 3'h1;
                end
                CSM_OP_BANK_DEC: begin
                    next_status[`CSM_SR_BANK] = statusWord[`CSM_SR_BANK] - 3'h1;
                end
                CSM_OP_FLAG_SWAP: begin
                    next_status[`CSM_SR_FLAGS] = altFlags;
                    next_alt = statusWord[`CSM_SR_FLAGS];
                end
                CSM_OP_FLAG_WRITE: begin
                    next_status[`CSM_SR_FLAGS] = opData[7:0];
                end
                CSM_OP_SR_RESTORE: begin
                    next_status = opData[15:0];
                end
                default: begin
                end
            endcase
        end
        if (next_status[`CSM_SR_WIDE]) begin
            next_status[`CSM_SR_BANK_TOP] = 1'b0;
        end
        next_status[`CSM_FL_Z5] = 1'b0;
        next_status[`CSM_FL_Z3] = 1'b0;
        next_alt[`CSM_FL_Z5] = 1'b0;
        next_alt[`CSM_FL_Z3] = 1'b0;
    end

    always_comb begin
        next_pc = pcWrite ? pcIn : pc;
        if (!statusWord[`CSM_SR_WIDE] && next_status[`CSM_SR_WIDE]) begin
            next_pc[31:16] = 16'h0;
        end
        if (!next_status[`CSM_SR_WIDE]) begin
            next_pc = next_pc & `CSM_PC_NARROW;
        end
    end

    // the active pointer follows the level in force when the write lands
    always_comb begin
        next_sysSp  = sysSp;
        next_userSp = userSp;
        if (spWrite) begin
            if (statusWord[`CSM_SR_LVL]) begin
                next_sysSp = spIn;
            end else begin
                next_userSp = spIn;
            end
        end
        if (crWe && (crAddr == `CSM_CR_USP)) begin
            next_userSp = opData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            statusWord <= {`CSM_RST_LVL, `CSM_RST_MASK, `CSM_RST_WIDE, `CSM_RST_BANK,
                           `CSM_RST_FLAGS};
            altFlags   <= `CSM_RST_FLAGS;
        end else begin
            statusWord <= next_status;
            altFlags   <= next_alt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pc <= `CSM_RST_PC;
        end else begin
            pc <= next_pc;
        end
    end

    // user pointer is deliberately left alone by reset
    always_ff @(posedge clk_sys) begin
        userSp <= next_userSp;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sysSp    <= `CSM_RST_SP;
            activeSp <= `CSM_RST_SP;
        end else begin
            sysSp    <= next_sysSp;
            activeSp <= next_status[`CSM_SR_LVL] ? next_sysSp : next_userSp;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            privFault <= 1'b0;
            irqAdmit  <= 1'b0;
        end else begin
            privFault <= fault && !irqTake;
            irqAdmit  <= admits(next_status[`CSM_SR_MASK], irqReqLevel);
        end
    end

    csm_ctrl_mem #(
        .AW (CR_AW),
        .DW (32)
    ) u_cr (
        .clk_sys (clk_sys),
        .we      (crWe),
        .wAddr   (crAddr),
        .wData   (opData),
        .re      (crRe),
        .rAddr   (crAddr),
        .rdData  (memRdData)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            crRdPend  <= 1'b0;
            crRdAddr  <= '0;
            crRdData  <= 32'h0;
            crRdValid <= 1'b0;
        end else begin
            crRdPend  <= crRe;
            crRdAddr  <= crAddr;
            crRdValid <= crRdPend;
            if (crRdPend) begin
                crRdData <= (crRdAddr == `CSM_CR_USP) ? userSp : memRdData;
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_reset_status: assert property (disable iff (1'b0) rst |=>
        statusWord[15:8] == {`CSM_RST_LVL, `CSM_RST_MASK, `CSM_RST_WIDE, `CSM_RST_BANK})
        else $error("status upper byte wrong after reset");

    a_reset_pcsp: assert property (disable iff (1'b0) rst |=>
        pc == `CSM_RST_PC && activeSp == `CSM_RST_SP)
        else $error("pc or stack wrong after reset");

    a_fault_blocks: assert property (opValid && privileged(opCode) &&
        !statusWord[`CSM_SR_LVL] && !irqTake
        |=> privFault && $stable(statusWord[15:8]) && !crRdPend)
        else $error("privileged op ran at user level");

    a_irq_mask: assert property (irqTake |=> statusWord[`CSM_SR_LVL] &&
        statusWord[`CSM_SR_MASK] == (($past(irqLevel) == 3'h7) ? 3'h7
                                     : $past(irqLevel) + 3'h1))
        else $error("irq acceptance mask wrong");

    a_to_user: assert property (doOp && opCode == CSM_OP_TO_USER
        |=> !statusWord[`CSM_SR_LVL] ##1 (activeSp == userSp || $past(irqTake)
            || $past(spWrite) || $past(crWe)))
        else $error("return to user failed");

    a_mask_now: assert property (doOp && opCode == CSM_OP_MASK_LOAD
        |=> irqAdmit == (($past(irqReqLevel) != 3'h0) &&
                         ($past(irqReqLevel) >= $past(opData[2:0]))))
        else $error("new mask not in effect at once");

    a_bank_wide: assert property (statusWord[`CSM_SR_WIDE]
        |-> !statusWord[`CSM_SR_BANK_TOP])
        else $error("bank top bit set in wide mode");

    a_bank_wrap: assert property (doOp && opCode == CSM_OP_BANK_INC &&
        !statusWord[`CSM_SR_WIDE] && statusWord[`CSM_SR_BANK] == 3'h7
        |=> statusWord[`CSM_SR_BANK] == 3'h0)
        else $error("bank increment did not wrap");

    a_bank_only: assert property (!(doOp && opCode inside {CSM_OP_BANK_LOAD,
        CSM_OP_BANK_INC, CSM_OP_BANK_DEC, CSM_OP_SR_RESTORE, CSM_OP_WIDEN})
        |=> $stable(statusWord[`CSM_SR_BANK]))
        else $error("bank changed by another op");

    a_zero_bits: assert property (!statusWord[5] && !statusWord[3] &&
        !altFlags[5] && !altFlags[3])
        else $error("fixed zero flag bits set");

    a_zero_flag: assert property (aluValid && !opValid && aluWidth == CSM_W16
        |=> statusWord[`CSM_FL_Z] == ($past(aluResult[15:0]) == 16'h0) &&
            statusWord[`CSM_FL_C] == $past(aluCarry))
        else $error("zero or carry flag wrong");

    a_sign_flag: assert property (aluValid && !opValid && aluWidth == CSM_W8
        |=> statusWord[`CSM_FL_S] == $past(aluResult[7]))
        else $error("sign flag wrong");

    a_half_carry: assert property (aluValid && !opValid && aluWidth != CSM_W32
        |=> statusWord[`CSM_FL_H] == ($past(aluA[4]) ^ $past(aluB[4]) ^ $past(aluResult[4])))
        else $error("half carry flag wrong");

    a_ovf_flag: assert property (aluValid && !opValid && aluKindOvf
        |=> statusWord[`CSM_FL_V] == $past(aluOverflow))
        else $error("overflow flag wrong");

    a_sub_flag: assert property (aluValid && !opValid
        |=> statusWord[`CSM_FL_N] == $past(aluSub))
        else $error("subtract flag wrong");

    a_flag_swap: assert property (doOp && opCode == CSM_OP_FLAG_SWAP &&
        !aluValid |=> statusWord[7:0] == $past(altFlags) &&
        altFlags == $past(statusWord[7:0]))
        else $error("flag swap wrong");

    a_widen_op: assert property (doOp && opCode == CSM_OP_WIDEN
        |=> statusWord[`CSM_SR_WIDE])
        else $error("widen op did not set width bit");

    a_widen_pc: assert property ($rose(statusWord[`CSM_SR_WIDE])
        |-> pc[31:16] == 16'h0)
        else $error("pc upper half not zeroed on widening");

    a_pc_narrow: assert property (!statusWord[`CSM_SR_WIDE]
        |-> pc[31:16] == 16'h0)
        else $error("narrow pc has upper bits");

    a_sp_select: assert property (statusWord[`CSM_SR_LVL]
        |-> activeSp == sysSp)
        else $error("system level uses wrong stack");

    a_user_sp: assert property (!statusWord[`CSM_SR_LVL]
        |-> activeSp == userSp)
        else $error("user level uses wrong stack");

    a_sys_sp_reset: assert property (disable iff (1'b0) rst |=>
        sysSp == `CSM_RST_SP)
        else $error("system stack not reset");

    a_cr_system: assert property (crWe || crRe
        |-> statusWord[`CSM_SR_LVL])
        else $error("control space reached at user level");

    c_nmi_take: cover property (irqTake && irqLevel == 3'h7);
    c_widen: cover property (doOp && opCode == CSM_OP_WIDEN);
    c_bank_under: cover property (doOp && opCode == CSM_OP_BANK_DEC &&
        statusWord[`CSM_SR_BANK] == 3'h0);
    c_cr_read: cover property (crRdValid);
    c_priv_fault: cover property (privFault);
endmodule
`default_nettype wire
